//--- inc/tw_pkg.sv
package tw_pkg;

	// ------------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE = 16'hff60;
	localparam logic [15:0] ADDR_CTRL = 16'hff61;
	localparam logic [15:0] ADDR_OWN = 16'hff62;
	localparam logic [15:0] ADDR_TIMING = 16'hff63;
	localparam logic [15:0] ADDR_SHIFT = 16'hff64;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [4:0] RST_MODE_LO = 5'h00;
	localparam logic [1:0] RST_WAIT = 2'h0;

	// ------------------------------------------------------------------
	// channel mode register fields
	// ------------------------------------------------------------------
	localparam int MODE_EN = 7;
	localparam int MODE_MATCH = 6;
	localparam int MODE_WAKE = 5;
	localparam int MODE_LO_MSB = 4;

	// ------------------------------------------------------------------
	// bus control and status register fields
	// ------------------------------------------------------------------
	localparam int CTRL_TXDIS = 7;
	localparam int CTRL_ACK_SEEN = 6;
	localparam int CTRL_ACK_AUTO = 5;
	localparam int CTRL_ACK_MAN = 4;
	localparam int CTRL_START_SEEN = 3;
	localparam int CTRL_STOP_SEEN = 2;
	localparam int CTRL_START_OUT = 1;
	localparam int CTRL_STOP_OUT = 0;

	// ------------------------------------------------------------------
	// interrupt timing register fields
	// ------------------------------------------------------------------
	localparam int TIM_CLD = 6;
	localparam int TIM_STOP = 5;
	localparam int TIM_SVAM = 4;
	localparam int TIM_CLC = 3;
	localparam int TIM_WREL = 2;

	// ------------------------------------------------------------------
	// encodings and counts
	// ------------------------------------------------------------------
	localparam logic [1:0] CLKSEL_TIMER = 2'h2;
	localparam logic [1:0] WAIT_8 = 2'h2;
	localparam logic [1:0] WAIT_9 = 2'h3;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int TIMER_DIV = 16;
	localparam logic [3:0] TIMER_HALF = 4'(TIMER_DIV / 2 - 1);

	typedef enum logic [1:0] {
		TW_IDLE,
		TW_ADDR,
		TW_DATA
	} tw_phase_e;

endpackage : tw_pkg

//--- verilog/tw_sync.sv
`timescale 1ns/100ps
module tw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule : tw_sync

//--- verilog/tw_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - address match flag is read-only and reads 0 while channel disabled.
// - timer-sourced bus clock runs at one sixteenth of timer output rate.
// - reset clears whole bus control and status register to zero.
// - transmit-disable bit 0 enables shifted-data driver, 1 disables it; ack drives still pull data.
// - ack flag sets on ack after transfer; clears on transfer, disable, reset.
// - auto ack drives data low around ninth falling edge; enable stays set.
// - writing manual ack bit pulls data low before next clock fall.
// - manual ack bit clears on clock fall after a rise, channel disable and transfer start.
// - start flag sets on start; clears on transfer, stop, disable, reset.
// - stop flag sets on stop; clears on transfer, mismatch, disable, reset.
// - stop, start and ack flags at bits 2, 3, 6 are read-only.
// - busy mode ends on transfer start or address received; bit kept.
// - wait mode 10 waits after 8th clock, 11 after 9th; 01 prohibited.
// - start-output bit clears output latch then self-clears; clears on off.
// - stop is data rising with clock high; start is data falling.
// - channel enable bit stops channel at 0 and runs it at 1.
module tw_ctrl (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// cpu register access
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	// two-wire bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// timer clock source
	input wire logic timer_two_output,
	// events
	output logic irq,
	output logic busy_mode
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic channel_enable, wakeup_enable, addr_match_flag;
	logic [4:0] mode_lo;
	logic tx_drive_disable, ack_detected, auto_ack_enable;
	logic manual_ack_trigger, start_detected, stop_detected;
	logic start_output_trigger, stop_output_trigger;
	logic [7:0] own_slave_address, serial_shift_reg;
	logic stop_irq_cause_select, svam, clc, wrel;
	logic [1:0] wait_mode;
	logic so_latch, master, hold, hold_pend, auto_drv, man_rise, scl_gen;
	logic [3:0] bit_cnt, div_cnt;
	tw_pkg::tw_phase_e phase;
	logic scl_prev, sda_prev, tmr_prev;

	logic next_channel_enable, next_wakeup_enable, next_addr_match_flag;
	logic [4:0] next_mode_lo;
	logic next_tx_drive_disable, next_ack_detected, next_auto_ack_enable;
	logic next_manual_ack_trigger, next_start_detected, next_stop_detected;
	logic next_start_output_trigger, next_stop_output_trigger;
	logic [7:0] next_own_slave_address, next_serial_shift_reg;
	logic next_stop_irq_cause_select, next_svam, next_clc, next_wrel;
	logic [1:0] next_wait_mode;
	logic next_so_latch, next_master, next_hold, next_hold_pend;
	logic next_auto_drv, next_man_rise, next_scl_gen, next_busy_mode;
	logic [3:0] next_bit_cnt, next_div_cnt;
	tw_pkg::tw_phase_e next_phase;
	logic next_irq, next_scl_oe, next_sda_oe;
	logic [7:0] next_cpu_rdata;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic s_scl, s_sda, s_tmr;

	tw_sync #(.WIDTH(3)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.async_in({scl_i, sda_i, timer_two_output}),
		.sync_out({s_scl, s_sda, s_tmr})
	);

	// ------------------------------------------------------------------
	// decode and bus events
	// ------------------------------------------------------------------
	logic wr_mode, wr_ctrl, wr_own, wr_tim, wr_shift;
	logic scl_rise, scl_fall, tmr_rise, start_cond, stop_cond;
	logic active, byte_done, ack_clk, addr_hit;
	logic [7:0] shift_in, ctrl_view, mode_view, tim_view;

	assign wr_mode = cpu_wr && (cpu_addr == tw_pkg::ADDR_MODE);
	assign wr_ctrl = cpu_wr && (cpu_addr == tw_pkg::ADDR_CTRL);
	assign wr_own = cpu_wr && (cpu_addr == tw_pkg::ADDR_OWN);
	assign wr_tim = cpu_wr && (cpu_addr == tw_pkg::ADDR_TIMING);
	assign wr_shift = cpu_wr && (cpu_addr == tw_pkg::ADDR_SHIFT);
	assign scl_rise = s_scl && !scl_prev;
	assign scl_fall = !s_scl && scl_prev;
	assign tmr_rise = s_tmr && !tmr_prev;
	assign start_cond = scl_prev && s_scl && sda_prev && !s_sda;
	assign stop_cond = scl_prev && s_scl && !sda_prev && s_sda;
	assign active = (phase != tw_pkg::TW_IDLE);
	assign byte_done = active && scl_rise && (bit_cnt == tw_pkg::BYTE_LAST);
	assign ack_clk = active && scl_rise && (bit_cnt == tw_pkg::ACK_BIT);
	assign shift_in = {serial_shift_reg[6:0], s_sda};
	assign addr_hit = svam ? (shift_in[7:1] == own_slave_address[7:1]) :
		(shift_in == own_slave_address);
	assign mode_view = {channel_enable, addr_match_flag && channel_enable,
		wakeup_enable, mode_lo};
	assign ctrl_view = {tx_drive_disable, ack_detected, auto_ack_enable,
		manual_ack_trigger, start_detected, stop_detected,
		start_output_trigger, stop_output_trigger};
	assign tim_view = {1'b0, channel_enable && s_scl, stop_irq_cause_select,
		svam, clc, wrel, wait_mode};

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_channel_enable = channel_enable;
		next_wakeup_enable = wakeup_enable;
		next_addr_match_flag = addr_match_flag;
		next_mode_lo = mode_lo;
		next_tx_drive_disable = tx_drive_disable;
		next_ack_detected = ack_detected;
		next_auto_ack_enable = auto_ack_enable;
		next_manual_ack_trigger = manual_ack_trigger;
		next_start_detected = start_detected;
		next_stop_detected = stop_detected;
		next_start_output_trigger = start_output_trigger;
		next_stop_output_trigger = stop_output_trigger;
		next_own_slave_address = own_slave_address;
		next_serial_shift_reg = serial_shift_reg;
		next_stop_irq_cause_select = stop_irq_cause_select;
		next_svam = svam;
		next_clc = clc;
		next_wrel = wrel;
		next_wait_mode = wait_mode;
		next_so_latch = so_latch;
		next_master = master;
		next_hold = hold;
		next_hold_pend = hold_pend;
		next_auto_drv = auto_drv;
		next_man_rise = man_rise;
		next_scl_gen = scl_gen;
		next_busy_mode = busy_mode;
		next_bit_cnt = bit_cnt;
		next_div_cnt = div_cnt;
		next_phase = phase;
		next_irq = 1'b0;
		// pending self-clearing actions from earlier writes
		if (start_output_trigger) begin
			next_so_latch = 1'b0;
			next_start_output_trigger = 1'b0;
		end
		if (stop_output_trigger) begin
			next_so_latch = 1'b1;
			next_stop_output_trigger = 1'b0;
		end
		if (wrel) begin
			next_hold = 1'b0;
			next_wrel = 1'b0;
		end
		// register writes
		if (wr_mode) begin
			next_channel_enable = cpu_wdata[tw_pkg::MODE_EN];
			next_wakeup_enable = cpu_wdata[tw_pkg::MODE_WAKE];
			next_mode_lo = cpu_wdata[tw_pkg::MODE_LO_MSB:0];
		end else if (wr_ctrl) begin
			// flags at bits 6, 3 and 2 are not taken from the write
			next_tx_drive_disable = cpu_wdata[tw_pkg::CTRL_TXDIS];
			next_auto_ack_enable = cpu_wdata[tw_pkg::CTRL_ACK_AUTO];
			if (cpu_wdata[tw_pkg::CTRL_ACK_MAN])
				next_manual_ack_trigger = 1'b1;
			if (cpu_wdata[tw_pkg::CTRL_START_OUT])
				next_start_output_trigger = 1'b1;
			if (cpu_wdata[tw_pkg::CTRL_STOP_OUT])
				next_stop_output_trigger = 1'b1;
			if (cpu_wdata[tw_pkg::CTRL_TXDIS] && !tx_drive_disable)
				next_busy_mode = 1'b1;
		end else if (wr_own) begin
			next_own_slave_address = cpu_wdata;
		end else if (wr_tim) begin
			next_stop_irq_cause_select = cpu_wdata[tw_pkg::TIM_STOP];
			next_svam = cpu_wdata[tw_pkg::TIM_SVAM];
			next_clc = cpu_wdata[tw_pkg::TIM_CLC];
			next_wrel = cpu_wdata[tw_pkg::TIM_WREL];
			next_wait_mode = cpu_wdata[1:0];
		end
		if (channel_enable) begin
			// transfer start: clears flags before any bus event sets them
			if (wr_shift) begin
				next_serial_shift_reg = cpu_wdata;
				next_so_latch = cpu_wdata[7];
				next_bit_cnt = '0;
				next_phase = tw_pkg::TW_DATA;
				next_master = (mode_lo[1:0] == tw_pkg::CLKSEL_TIMER);
				next_ack_detected = 1'b0;
				next_start_detected = 1'b0;
				next_stop_detected = 1'b0;
				next_manual_ack_trigger = 1'b0;
				next_busy_mode = 1'b0;
				next_hold = 1'b0;
				next_hold_pend = 1'b0;
				next_scl_gen = 1'b1;
				next_div_cnt = '0;
			end
			if (scl_fall) begin
				if (active && (bit_cnt < tw_pkg::ACK_BIT))
					next_so_latch = serial_shift_reg[7];
				else if (active)
					next_so_latch = 1'b1;
				if (auto_drv)
					next_auto_drv = 1'b0;
				else if (active && auto_ack_enable &&
					(bit_cnt == tw_pkg::ACK_BIT))
					next_auto_drv = 1'b1;
				if (hold_pend) begin
					next_hold = 1'b1;
					next_hold_pend = 1'b0;
				end
				if (man_rise) begin
					next_manual_ack_trigger = 1'b0;
					next_man_rise = 1'b0;
				end
			end
			if (scl_rise && manual_ack_trigger)
				next_man_rise = 1'b1;
			if (active && scl_rise && (bit_cnt < tw_pkg::ACK_BIT)) begin
				next_serial_shift_reg = shift_in;
				next_bit_cnt = bit_cnt + 4'h1;
			end
			if (byte_done) begin
				if (phase == tw_pkg::TW_ADDR) begin
					next_busy_mode = 1'b0;
					next_phase = tw_pkg::TW_DATA;
					next_addr_match_flag = addr_hit;
					if (!addr_hit)
						next_stop_detected = 1'b0;
					if (wakeup_enable && addr_hit)
						next_irq = 1'b1;
				end
				if (wait_mode != tw_pkg::WAIT_9 && !wakeup_enable)
					next_irq = 1'b1;
				if (wait_mode == tw_pkg::WAIT_8)
					next_hold_pend = 1'b1;
			end
			if (ack_clk) begin
				if (!s_sda)
					next_ack_detected = 1'b1;
				next_phase = tw_pkg::TW_IDLE;
				next_bit_cnt = '0;
				if (wait_mode == tw_pkg::WAIT_9) begin
					next_hold_pend = 1'b1;
					if (!wakeup_enable)
						next_irq = 1'b1;
				end
			end
			if (start_cond) begin
				next_start_detected = 1'b1;
				next_phase = tw_pkg::TW_ADDR;
				next_bit_cnt = '0;
			end
			if (stop_cond) begin
				next_stop_detected = 1'b1;
				next_start_detected = 1'b0;
				next_phase = tw_pkg::TW_IDLE;
				next_bit_cnt = '0;
				next_auto_drv = 1'b0;
				if (stop_irq_cause_select)
					next_irq = 1'b1;
			end
			// master clock: one bus clock per sixteen timer periods
			if (master && active && !hold) begin
				if (tmr_rise) begin
					if (div_cnt == tw_pkg::TIMER_HALF) begin
						next_div_cnt = '0;
						next_scl_gen = !scl_gen;
					end else begin
						next_div_cnt = div_cnt + 4'h1;
					end
				end
			end else if (!wr_shift) begin
				next_div_cnt = '0;
				next_scl_gen = 1'b1;
			end
		end else begin
			next_addr_match_flag = 1'b0;
			next_ack_detected = 1'b0;
			next_start_detected = 1'b0;
			next_stop_detected = 1'b0;
			next_manual_ack_trigger = 1'b0;
			next_start_output_trigger = 1'b0;
			next_stop_output_trigger = 1'b0;
			next_phase = tw_pkg::TW_IDLE;
			next_bit_cnt = '0;
			next_hold = 1'b0;
			next_hold_pend = 1'b0;
			next_auto_drv = 1'b0;
			next_man_rise = 1'b0;
			next_scl_gen = 1'b1;
			next_div_cnt = '0;
		end
		// open-drain drivers: enable means pulling the line low
		next_sda_oe = next_channel_enable && (next_auto_drv ||
			next_manual_ack_trigger ||
			(!next_tx_drive_disable && !next_so_latch));
		next_scl_oe = next_channel_enable && (next_hold || next_busy_mode ||
			(next_phase == tw_pkg::TW_IDLE && !next_clc) ||
			(next_master && next_phase != tw_pkg::TW_IDLE &&
			!next_scl_gen));
		next_cpu_rdata = cpu_rdata;
		if (cpu_rd) begin
			if (cpu_addr == tw_pkg::ADDR_MODE)
				next_cpu_rdata = mode_view;
			else if (cpu_addr == tw_pkg::ADDR_CTRL)
				next_cpu_rdata = ctrl_view;
			else if (cpu_addr == tw_pkg::ADDR_OWN)
				next_cpu_rdata = own_slave_address;
			else if (cpu_addr == tw_pkg::ADDR_TIMING)
				next_cpu_rdata = tim_view;
			else if (cpu_addr == tw_pkg::ADDR_SHIFT)
				next_cpu_rdata = serial_shift_reg;
			else
				next_cpu_rdata = tw_pkg::RST_REG;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			channel_enable <= 1'b0;
			wakeup_enable <= 1'b0;
			addr_match_flag <= 1'b0;
			mode_lo <= tw_pkg::RST_MODE_LO;
			{tx_drive_disable, ack_detected, auto_ack_enable,
				manual_ack_trigger, start_detected, stop_detected,
				start_output_trigger, stop_output_trigger} <=
				tw_pkg::RST_REG;
			own_slave_address <= tw_pkg::RST_REG;
			serial_shift_reg <= tw_pkg::RST_REG;
			stop_irq_cause_select <= 1'b0;
			svam <= 1'b0;
			clc <= 1'b0;
			wrel <= 1'b0;
			wait_mode <= tw_pkg::RST_WAIT;
			so_latch <= 1'b1;
			master <= 1'b0;
			hold <= 1'b0;
			hold_pend <= 1'b0;
			auto_drv <= 1'b0;
			man_rise <= 1'b0;
			scl_gen <= 1'b1;
			busy_mode <= 1'b0;
			bit_cnt <= '0;
			div_cnt <= '0;
			phase <= tw_pkg::TW_IDLE;
			scl_prev <= 1'b0;
			sda_prev <= 1'b0;
			tmr_prev <= 1'b0;
			irq <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			cpu_rdata <= tw_pkg::RST_REG;
		end else if (ce) begin
			channel_enable <= next_channel_enable;
			wakeup_enable <= next_wakeup_enable;
			addr_match_flag <= next_addr_match_flag;
			mode_lo <= next_mode_lo;
			tx_drive_disable <= next_tx_drive_disable;
			ack_detected <= next_ack_detected;
			auto_ack_enable <= next_auto_ack_enable;
			manual_ack_trigger <= next_manual_ack_trigger;
			start_detected <= next_start_detected;
			stop_detected <= next_stop_detected;
			start_output_trigger <= next_start_output_trigger;
			stop_output_trigger <= next_stop_output_trigger;
			own_slave_address <= next_own_slave_address;
			serial_shift_reg <= next_serial_shift_reg;
			stop_irq_cause_select <= next_stop_irq_cause_select;
			svam <= next_svam;
			clc <= next_clc;
			wrel <= next_wrel;
			wait_mode <= next_wait_mode;
			so_latch <= next_so_latch;
			master <= next_master;
			hold <= next_hold;
			hold_pend <= next_hold_pend;
			auto_drv <= next_auto_drv;
			man_rise <= next_man_rise;
			scl_gen <= next_scl_gen;
			busy_mode <= next_busy_mode;
			bit_cnt <= next_bit_cnt;
			div_cnt <= next_div_cnt;
			phase <= next_phase;
			scl_prev <= s_scl;
			sda_prev <= s_sda;
			tmr_prev <= s_tmr;
			irq <= next_irq;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			cpu_rdata <= next_cpu_rdata;
		end
	end

endmodule : tw_ctrl

//--- tb/tw_ctrl_properties.sv
`timescale 1ns/100ps
module tw_ctrl_checker (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// register port
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	// bus pins and events
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic irq,
	input wire logic busy_mode
);
	// ------------------------------------------------------------------
	// shadow of the written control bits
	// ------------------------------------------------------------------
	logic en, en_d, txdis, next_en, next_txdis, wr_mode, wr_ctrl;
	logic [1:0] clk_sel, next_sel;
	assign wr_mode = ce && cpu_wr && cpu_addr == tw_pkg::ADDR_MODE;
	assign wr_ctrl = ce && cpu_wr && cpu_addr == tw_pkg::ADDR_CTRL;
	always_comb begin
		next_en = wr_mode ? cpu_wdata[tw_pkg::MODE_EN] : en;
		next_sel = wr_mode ? cpu_wdata[1:0] : clk_sel;
		next_txdis = wr_ctrl ? cpu_wdata[tw_pkg::CTRL_TXDIS] : txdis;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			en <= 1'b0;
			en_d <= 1'b0;
			clk_sel <= 2'h0;
			txdis <= 1'b0;
		end else begin
			en <= next_en;
			en_d <= en;
			clk_sel <= next_sel;
			txdis <= next_txdis;
		end
	end
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_ack_req;
		en && wr_ctrl && cpu_wdata[tw_pkg::CTRL_ACK_MAN];
	endsequence
	sequence s_start_req;
		en && !txdis && wr_ctrl && cpu_wdata[1] && !cpu_wdata[0]
			&& !cpu_wdata[7];
	endsequence
	sequence s_off;
		!en && !en_d;
	endsequence
	property p_manual_ack;
		s_ack_req |=> sda_oe;
	endproperty
	property p_start_out;
		s_start_req |-> ##[1:3] sda_oe;
	endproperty
	property p_quiet_off;
		s_off |-> !scl_oe && !sda_oe;
	endproperty
	property p_match_off;
		ce && cpu_rd && cpu_addr == tw_pkg::ADDR_MODE && !en
			|=> !cpu_rdata[tw_pkg::MODE_MATCH];
	endproperty
	property p_flags_off;
		s_off ##0 (ce && cpu_rd && cpu_addr == tw_pkg::ADDR_CTRL)
			|=> (cpu_rdata & 8'h5f) == 8'h00;
	endproperty
	property p_irq_pulse;
		irq |=> !irq;
	endproperty
	property p_busy_set;
		en && !txdis && wr_ctrl && cpu_wdata[7] |-> ##[1:2] busy_mode;
	endproperty
	property p_busy_end;
		busy_mode && en && ce && cpu_wr && cpu_addr == tw_pkg::ADDR_SHIFT
			|-> ##[1:2] !busy_mode;
	endproperty
	property p_wait_release;
		en && clk_sel != 2'h2 && !busy_mode && scl_oe && ce && cpu_wr
			&& cpu_addr == tw_pkg::ADDR_TIMING && cpu_wdata[2]
			&& cpu_wdata[3] |-> ##[1:2] !scl_oe;
	endproperty
	a_manual_ack: assert property (p_manual_ack)
		else $error("manual ack did not drive data line");
	a_start_out: assert property (p_start_out)
		else $error("start output did not pull data line");
	a_quiet_off: assert property (p_quiet_off)
		else $error("disabled channel drives a line");
	a_match_off: assert property (p_match_off)
		else $error("address match flag set while disabled");
	a_flags_off: assert property (p_flags_off)
		else $error("status bits not cleared while disabled");
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("interrupt longer than one cycle");
	a_busy_set: assert property (p_busy_set)
		else $error("busy mode not entered");
	a_busy_end: assert property (p_busy_end)
		else $error("busy mode not ended by transfer start");
	a_wait_release: assert property (p_wait_release)
		else $error("wait hold not released");
endmodule : tw_ctrl_checker
bind tw_ctrl tw_ctrl_checker u_chk (.mclk, .nrst, .ce, .cpu_addr, .cpu_wr,
	.cpu_rd, .cpu_wdata, .cpu_rdata, .scl_oe, .sda_oe, .irq, .busy_mode);

//--- tb/tw_bus_model.sv
`timescale 1ns/100ps
module tw_bus_model (
	// line levels
	input wire logic scl_line,
	input wire logic sda_line,
	// pulls, high drives the line low
	output logic scl_pull,
	output logic sda_pull
);
	localparam int HALF = 40;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// bounded wait, the device may stretch the clock
	task automatic rise_scl;
		int n;
		n = 0;
		scl_pull = 1'b0;
		while (scl_line !== 1'b1 && n < 500) begin
			#8;
			n++;
		end
	endtask : rise_scl
	task automatic start_c;
		#HALF;
		sda_pull = 1'b1;
		#HALF;
		scl_pull = 1'b1;
		#20;
	endtask : start_c
	task automatic stop_c;
		scl_pull = 1'b1;
		#20;
		sda_pull = 1'b1;
		#HALF;
		rise_scl();
		#HALF;
		sda_pull = 1'b0;
		#HALF;
	endtask : stop_c
	task automatic send_byte(input logic [7:0] b, input logic give_ack,
		output logic ack);
		scl_pull = 1'b1;
		#20;
		for (int i = 7; i >= 0; i--) begin
			sda_pull = ~b[i];
			#HALF;
			rise_scl();
			#HALF;
			scl_pull = 1'b1;
			#20;
		end
		sda_pull = give_ack;
		#HALF;
		rise_scl();
		ack = (sda_line === 1'b0);
		#HALF;
		scl_pull = 1'b1;
		#20;
		sda_pull = 1'b0;
	endtask : send_byte
endmodule : tw_bus_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic mclk, nrst, ce, cpu_wr, cpu_rd, timer_two_output, ack, sda_seen;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, d;
	logic scl_o, scl_oe, sda_o, sda_oe, irq, busy_mode;
	logic scl_pull, sda_pull, scl_line, sda_line;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_irq = 0;
	realtime t1, t2;
	// open-drain lines with pull-ups
	assign scl_line = !(scl_oe === 1'b1 || scl_pull === 1'b1);
	assign sda_line = !(sda_oe === 1'b1 || sda_pull === 1'b1);
	tw_ctrl dut (.mclk, .nrst, .ce, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
		.cpu_rdata, .scl_i(scl_line), .scl_o, .scl_oe, .sda_i(sda_line),
		.sda_o, .sda_oe, .timer_two_output, .irq, .busy_mode);
	tw_bus_model u_bus (.scl_line, .sda_line, .scl_pull, .sda_pull);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		timer_two_output = 1'b0;
		forever #32 timer_two_output = ~timer_two_output;
	end
	always @(posedge mclk) begin
		if (irq === 1'b1) n_irq++;
		if (sda_oe === 1'b1) sda_seen = 1'b1;
	end
	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge mclk);
		cpu_addr = a;
		cpu_wdata = v;
		cpu_wr = 1'b1;
		@(negedge mclk);
		cpu_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(negedge mclk);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge mclk);
		cpu_rd = 1'b0;
		@(negedge mclk);
		d = cpu_rdata;
	endtask : rd
	task automatic results;
		if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h00);
		rd(tw_pkg::ADDR_MODE);
		check(d, 8'h00);
	endtask : t_reset
	task automatic t_ro;
		wr(tw_pkg::ADDR_MODE, 8'h80);
		wr(tw_pkg::ADDR_TIMING, 8'h0b);
		wr(tw_pkg::ADDR_CTRL, 8'h4c);
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h00);
	endtask : t_ro
	task automatic t_trig;
		wr(tw_pkg::ADDR_CTRL, 8'h02);
		repeat (3) @(negedge mclk);
		check(sda_oe, 1'b1);
		wr(tw_pkg::ADDR_CTRL, 8'h01);
		repeat (8) @(negedge mclk);
		check(sda_oe, 1'b0);
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h04);
	endtask : t_trig
	task automatic t_match;
		wr(tw_pkg::ADDR_OWN, 8'ha4);
		wr(tw_pkg::ADDR_CTRL, 8'h20);
		wr(tw_pkg::ADDR_SHIFT, 8'hff);
		u_bus.start_c();
		rd(tw_pkg::ADDR_CTRL);
		check(d & 8'h0c, 8'h08);
		n_irq = 0;
		u_bus.send_byte(8'ha4, 1'b0, ack);
		repeat (6) @(negedge mclk);
		check(ack, 1'b1);
		check(n_irq, 1);
		check(scl_oe, 1'b1);
		rd(tw_pkg::ADDR_MODE);
		check(d[6], 1'b1);
		rd(tw_pkg::ADDR_CTRL);
		check(d & 8'h60, 8'h60);
		wr(tw_pkg::ADDR_TIMING, 8'h0f);
		repeat (2) @(negedge mclk);
		check(scl_oe, 1'b0);
		wr(tw_pkg::ADDR_SHIFT, 8'h00);
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h20);
		wr(tw_pkg::ADDR_MODE, 8'h00);
		rd(tw_pkg::ADDR_MODE);
		check(d, 8'h00);
		u_bus.stop_c();
	endtask : t_match
	task automatic t_mack;
		wr(tw_pkg::ADDR_MODE, 8'h80);
		wr(tw_pkg::ADDR_CTRL, 8'h00);
		wr(tw_pkg::ADDR_CTRL, 8'h10);
		check(sda_oe, 1'b1);
		wr(tw_pkg::ADDR_MODE, 8'h00);
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h00);
		check(sda_oe, 1'b0);
	endtask : t_mack
	task automatic t_busy;
		wr(tw_pkg::ADDR_MODE, 8'h80);
		wr(tw_pkg::ADDR_CTRL, 8'h80);
		@(negedge mclk);
		check(busy_mode, 1'b1);
		wr(tw_pkg::ADDR_SHIFT, 8'h00);
		@(negedge mclk);
		check(busy_mode, 1'b0);
		rd(tw_pkg::ADDR_CTRL);
		check(d[7], 1'b1);
		sda_seen = 1'b0;
		u_bus.send_byte(8'hff, 1'b0, ack);
		check(sda_seen, 1'b0);
		check({scl_o, sda_o}, 2'b00);
		wr(tw_pkg::ADDR_MODE, 8'h00);
		u_bus.stop_c();
		wr(tw_pkg::ADDR_CTRL, 8'h00);
		wr(tw_pkg::ADDR_MODE, 8'h80);
		wr(tw_pkg::ADDR_SHIFT, 8'h00);
		sda_seen = 1'b0;
		u_bus.send_byte(8'hff, 1'b0, ack);
		check(sda_seen, 1'b1);
		wr(tw_pkg::ADDR_MODE, 8'h00);
		u_bus.stop_c();
	endtask : t_busy
	task automatic t_timer;
		wr(tw_pkg::ADDR_MODE, 8'h82);
		wr(tw_pkg::ADDR_CTRL, 8'h02);
		wr(tw_pkg::ADDR_SHIFT, 8'h55);
		repeat (2) @(posedge scl_oe);
		t1 = $realtime;
		@(posedge scl_oe);
		t2 = $realtime;
		check(32'(int'(t2 - t1)), 32'd1024);
		wr(tw_pkg::ADDR_MODE, 8'h00);
	endtask : t_timer
	task automatic t_wake;
		wr(tw_pkg::ADDR_CTRL, 8'h80);
		wr(tw_pkg::ADDR_MODE, 8'h80);
		wr(tw_pkg::ADDR_SHIFT, 8'hff);
		wr(tw_pkg::ADDR_TIMING, 8'h2b);
		wr(tw_pkg::ADDR_MODE, 8'ha0);
		n_irq = 0;
		u_bus.start_c();
		u_bus.send_byte(8'h12, 1'b0, ack);
		repeat (6) @(negedge mclk);
		check(n_irq, 0);
		check(scl_oe, 1'b1);
		wr(tw_pkg::ADDR_TIMING, 8'h2f);
		u_bus.stop_c();
		check(n_irq, 1);
		rd(tw_pkg::ADDR_CTRL);
		check(d, 8'h84);
		wr(tw_pkg::ADDR_MODE, 8'h00);
	endtask : t_wake
	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_addr = 16'h0000;
		cpu_wdata = 8'h00;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		t_ro();
		t_trig();
		t_match();
		t_mack();
		t_busy();
		t_timer();
		t_wake();
		results();
	end
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
endmodule : tb_top
